// ---- common/lptu_pkg.sv ----
// Package of constants and types for the low power tick unit
package lptu_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] CTRL_STATUS_OFS = 8'h00;
    localparam logic [7:0] PRESCALE_OFS    = 8'h04;
    localparam logic [7:0] COMPARE_OFS     = 8'h08;
    localparam logic [7:0] COUNT_OFS       = 8'h0c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CS_ENABLE_BIT   = 0;
    localparam int CS_MODE_BIT     = 1;
    localparam int CS_POLARITY_BIT = 3;
    localparam int CS_IRQ_EN_BIT   = 6;
    localparam int CS_FLAG_BIT     = 7;
    localparam int PS_SEL_LSB      = 0;
    localparam int PS_BYPASS_BIT   = 2;
    localparam int PS_DIV_LSB      = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [3:0]  DIV_RST     = 4'h0;
    localparam logic [1:0]  SEL_RST     = 2'h0;

    // Number of synchroniser stages in front of the selected source
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        LPTU_IDLE,
        LPTU_ADDR,
        LPTU_WDATA
    } lptu_bus_st_t;

    typedef struct packed {
        logic        enable;
        logic        pulse_mode;
        logic        polarity_low;
        logic        irq_enable;
        logic        compare_flag;
        logic [1:0]  clock_source_sel;
        logic        filter_bypass;
        logic [3:0]  divide;
        logic [15:0] compare_val;
    } lptu_cfg_t;

    typedef struct packed {
        lptu_cfg_t   cfg;
        logic [15:0] count;
        logic [15:0] prescale_cnt;
        logic        filt_out;
        logic [SYNC_STAGES-1:0] sync;
        logic        sync_prev;
        logic        hw_trigger;
        logic        trig_hold;
        logic        irq;
        logic        bus_pending;
        logic        bus_write;
        logic [7:0]  bus_addr;
        logic [31:0] rdata;
    } lptu_state_t;

endpackage

// ---- core/lptu_timer.sv ----
// Low power tick unit: 16-bit timer / pulse counter with AHB-Lite registers
`timescale 1ns/1ps
module lptu_timer
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [3:0]  src_clk,
    input  wire logic        pulse_in,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             hw_trigger,
    output logic             irq
);

    lptu_pkg::lptu_state_t st_reg;
    lptu_pkg::lptu_state_t st_next;

    // ****************************************
    // Combinational next state
    // ****************************************
    logic        src_level;
    logic        sync_rise;
    logic        tick;
    logic        inc;
    logic        match;
    logic [15:0] div_mask;
    logic [15:0] filt_len;
    logic        sample_in;
    logic        addr_phase;
    logic [31:0] rd_word;

    always_comb
    begin
        st_next  = st_reg;
        // Source mux: clock in time mode, pin in pulse mode
        src_level = st_reg.cfg.pulse_mode ?
                    (pulse_in ^ st_reg.cfg.polarity_low) :
                    src_clk[st_reg.cfg.clock_source_sel];
        // Until enabled the sampled source is held asserted
        sample_in = st_reg.cfg.enable ? src_level : 1'b1;
        st_next.sync = {st_reg.sync[lptu_pkg::SYNC_STAGES-2:0], sample_in};
        // Only the last stage is looked at, two edges of latency
        st_next.sync_prev = st_reg.sync[lptu_pkg::SYNC_STAGES-1];
        sync_rise = st_reg.sync[lptu_pkg::SYNC_STAGES-1] & ~st_reg.sync_prev;
        div_mask  = 16'((32'h2 << st_reg.cfg.divide) - 32'h1);
        filt_len  = 16'((32'h1 << st_reg.cfg.divide) - 32'h1);
        tick = 1'b0;
        // Shared prescaler / filter stage
        if (!st_reg.cfg.enable)
        begin
            st_next.prescale_cnt = 16'h0000;
            st_next.filt_out     = 1'b1; // Starts asserted on enable
        end
        else if (st_reg.cfg.filter_bypass)
        begin
            tick = sync_rise; // Direct count from source
        end
        else if (!st_reg.cfg.pulse_mode)
        begin
            // Divide by 2^(divide+1) source rising edges
            if (sync_rise)
            begin
                st_next.prescale_cnt = 16'(st_reg.prescale_cnt + 16'h0001);
                if ((st_reg.prescale_cnt & div_mask) == div_mask)
                begin
                    st_next.prescale_cnt = 16'h0000;
                    tick = 1'b1;
                end
            end
        end
        else
        begin
            // Sample on each source clock rising edge only
            if (src_clk[st_reg.cfg.clock_source_sel] && !st_reg.trig_hold)
            begin
                if (st_reg.sync[lptu_pkg::SYNC_STAGES-1] == st_reg.filt_out)
                    st_next.prescale_cnt = 16'h0000;
                else if (st_reg.prescale_cnt >= filt_len)
                begin
                    // Level held 2^divide samples, follow it
                    st_next.filt_out     = ~st_reg.filt_out;
                    st_next.prescale_cnt = 16'h0000;
                    tick = ~st_reg.filt_out; // Count on assertion
                end
                else
                    st_next.prescale_cnt = 16'(st_reg.prescale_cnt + 16'h0001);
            end
        end
        st_next.trig_hold = src_clk[st_reg.cfg.clock_source_sel];
        inc   = st_reg.cfg.enable & tick;
        match = st_reg.count == st_reg.cfg.compare_val;
        // Counter clears when disabled, wraps to zero on overflow
        if (!st_reg.cfg.enable)
            st_next.count = 16'h0000;
        else if (inc)
            st_next.count = 16'(st_reg.count + 16'h0001);
        // Trigger follows compare, held until disabled if compare is zero
        if (!st_reg.cfg.enable)
            st_next.hw_trigger = 1'b0;
        else if (inc)
            st_next.hw_trigger = match |
                (st_reg.hw_trigger & (st_reg.cfg.compare_val == 16'h0000));

        // ****************************************
        // AHB-Lite slave, zero wait states
        // ****************************************
        addr_phase = hsel & htrans[1] & hready;
        st_next.bus_pending = addr_phase;
        if (addr_phase)
        begin
            st_next.bus_write = hwrite;
            st_next.bus_addr  = {haddr[7:2], 2'b00};
        end
        if (st_reg.bus_pending && st_reg.bus_write)
        begin
            unique case (st_reg.bus_addr)
                lptu_pkg::CTRL_STATUS_OFS:
                begin
                    st_next.cfg.enable       = hwdata[lptu_pkg::CS_ENABLE_BIT];
                    st_next.cfg.pulse_mode   = hwdata[lptu_pkg::CS_MODE_BIT];
                    st_next.cfg.polarity_low = hwdata[lptu_pkg::CS_POLARITY_BIT];
                    st_next.cfg.irq_enable   = hwdata[lptu_pkg::CS_IRQ_EN_BIT];
                    // Write one clears flag
                    if (hwdata[lptu_pkg::CS_FLAG_BIT])
                        st_next.cfg.compare_flag = 1'b0;
                end
                lptu_pkg::PRESCALE_OFS:
                begin
                    st_next.cfg.clock_source_sel = hwdata[lptu_pkg::PS_SEL_LSB +: 2];
                    st_next.cfg.filter_bypass    = hwdata[lptu_pkg::PS_BYPASS_BIT];
                    st_next.cfg.divide           = hwdata[lptu_pkg::PS_DIV_LSB +: 4];
                end
                lptu_pkg::COMPARE_OFS: st_next.cfg.compare_val = hwdata[15:0];
                default: ;
            endcase
        end
        // Disable clears the flag; a compare event wins over a clear
        if (!st_next.cfg.enable)
            st_next.cfg.compare_flag = 1'b0;
        if (inc && match)
            st_next.cfg.compare_flag = 1'b1;
        // Read word registered at the address phase so it stands in the data phase;
        // taken from the next state so a write just ahead of it is already seen
        rd_word = 32'h0000_0000;
        unique case ({haddr[7:2], 2'b00})
            lptu_pkg::CTRL_STATUS_OFS:
            begin
                rd_word[lptu_pkg::CS_ENABLE_BIT]   = st_next.cfg.enable;
                rd_word[lptu_pkg::CS_MODE_BIT]     = st_next.cfg.pulse_mode;
                rd_word[lptu_pkg::CS_POLARITY_BIT] = st_next.cfg.polarity_low;
                rd_word[lptu_pkg::CS_IRQ_EN_BIT]   = st_next.cfg.irq_enable;
                rd_word[lptu_pkg::CS_FLAG_BIT]     = st_next.cfg.compare_flag;
            end
            lptu_pkg::PRESCALE_OFS:
            begin
                rd_word[lptu_pkg::PS_SEL_LSB +: 2]  = st_next.cfg.clock_source_sel;
                rd_word[lptu_pkg::PS_BYPASS_BIT]    = st_next.cfg.filter_bypass;
                rd_word[lptu_pkg::PS_DIV_LSB +: 4]  = st_next.cfg.divide;
            end
            lptu_pkg::COMPARE_OFS: rd_word = {16'h0000, st_next.cfg.compare_val};
            lptu_pkg::COUNT_OFS:   rd_word = {16'h0000, st_next.count};
            default:               rd_word = 32'h0000_0000;
        endcase
        if (addr_phase && !hwrite)
            st_next.rdata = rd_word;
        st_next.irq = st_next.cfg.compare_flag & st_next.cfg.irq_enable;
    end

    // ****************************************
    // State register, power-on reset only
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (srst) // Tie to power-on / low voltage reset only
        begin
            st_reg <= '0;
            st_reg.filt_out <= 1'b1;
            st_reg.sync <= '1;
            st_reg.sync_prev <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from flip-flops; hreadyout and hresp tied to constants
    assign hrdata     = st_reg.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hw_trigger = st_reg.hw_trigger;
    assign irq        = st_reg.irq;

    // ****************************************
    // Assertions
    // ****************************************
    trig_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        !st_reg.cfg.enable |=> !hw_trigger)
        else $error("trigger high while disabled");
    flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        (inc && match) |=> (st_reg.cfg.compare_flag && hw_trigger))
        else $error("compare event lost");
    cnt_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
        !st_reg.cfg.enable |=> (st_reg.count == 16'h0000))
        else $error("count not cleared");
    cnt_inc_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg.cfg.enable && !inc) |=> $stable(st_reg.count))
        else $error("count moved without tick");
    filt_init_a: assert property (@(posedge clk_sys) disable iff (srst)
        !st_reg.cfg.enable |=> st_reg.filt_out)
        else $error("filter not asserted at start");
    rd_upper_a: assert property (@(posedge clk_sys) disable iff (srst)
        (addr_phase && !hwrite && ({haddr[7:2], 2'b00} == lptu_pkg::COUNT_OFS))
        |=> (hrdata == {16'h0000, $past(st_next.count)}))
        else $error("count read word wrong");
    zero_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        (hw_trigger && st_reg.cfg.compare_val == 16'h0000 && st_next.cfg.enable
         && st_reg.cfg.enable) |=> hw_trigger)
        else $error("zero compare trigger dropped");
    byp_tick_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg.cfg.enable && st_reg.cfg.filter_bypass && sync_rise) |-> tick)
        else $error("bypass edge not counted");

endmodule

// ---- tb/lptu_far_model.sv ----
// Far side model: prescaler clock sources and the external pulse pin
`timescale 1ns/1ps
module lptu_far_model
(
    input  wire logic       clk_sys,
    output logic      [3:0] src_clk,
    output logic            pulse_in
);
    // ****************************************
    // Clock sources and pulse pin
    // ****************************************
    // Sources run before any enable, phase unrelated to clk_sys, all below clk_sys/4
    initial
    begin
        src_clk  = 4'h0;
        pulse_in = 1'b0;
    end
    always #83 src_clk[0] = ~src_clk[0];
    always #127 src_clk[1] = ~src_clk[1];
    always #161 src_clk[2] = ~src_clk[2];
    // Source 3 never toggles, the power saving pick for bypassed pulse counting

    // Level change on the pin, launched after a clock edge
    task automatic set_level(input logic v);
        @(posedge clk_sys);
        pulse_in <= v;
    endtask

    // Pulse train; a short high time makes a glitch for the filter
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n)
        begin
            @(posedge clk_sys);
            pulse_in <= 1'b1;
            repeat (hi) @(posedge clk_sys);
            pulse_in <= 1'b0;
            repeat (lo) @(posedge clk_sys);
        end
    endtask
endmodule

// ---- tb/test_lptu_timer.sv ----
// Self-checking testbench of the low power tick unit
`timescale 1ns/1ps
module test_lptu_timer;
    logic        clk_sys;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        hw_trigger;
    logic        irq;
    logic [3:0]  src_clk;
    logic        pulse_in;
    logic [31:0] rd;
    int          n_mismatch;
    int          comparisons;
    int          cycles;

    lptu_far_model i_far (.clk_sys(clk_sys), .src_clk(src_clk), .pulse_in(pulse_in));
    // Single slave, so its ready is the bus ready
    lptu_timer i_dut (.clk_sys(clk_sys), .srst(srst), .src_clk(src_clk),
        .pulse_in(pulse_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hw_trigger(hw_trigger), .irq(irq));

    // ****************************************
    // Clock, timeout, report
    // ****************************************
    always #10 clk_sys = ~clk_sys;
    // Ceiling well above the few thousand cycles the tests need
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Range compare; lo equal to hi makes it exact, unknowns never match
    task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        comparisons++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    // One AHB-Lite single word transfer, zero or more wait states
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs();
        ahb(1'b0, lptu_pkg::COMPARE_OFS, 32'h0, rd);
        check(rd, 32'h0, 32'h0);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h0, 32'h0);
        ahb(1'b1, lptu_pkg::COMPARE_OFS, 32'hffff_a5c3, rd);
        ahb(1'b0, lptu_pkg::COMPARE_OFS, 32'h0, rd);
        check(rd, 32'h0000_a5c3, 32'h0000_a5c3);
        ahb(1'b1, lptu_pkg::COUNT_OFS, 32'h0000_1234, rd);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h0, 32'h0);
        ahb(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h0, 32'h0);
        check({31'h0, hresp}, 32'h0, 32'h0);
        $display("test_regs done");
    endtask

    // Time counting for a source, bypass and divide; disabling clears the count
    task automatic time_count(input logic [1:0] sel, input logic byp, input logic [3:0] div,
                              input int wait_cyc, input logic [31:0] lo, input logic [31:0] hi);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        ahb(1'b1, lptu_pkg::PRESCALE_OFS, {25'h0, div, byp, sel}, rd);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h1, rd);
        repeat (wait_cyc) @(posedge clk_sys);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, lo, hi);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h0, 32'h0);
        $display("time_count sel %0d done", sel);
    endtask

    task automatic test_compare();
        int k;
        ahb(1'b1, lptu_pkg::COMPARE_OFS, 32'h5, rd);
        ahb(1'b1, lptu_pkg::PRESCALE_OFS, 32'h4, rd);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h41, rd);
        for (k = 0; k < 300 && hw_trigger !== 1'b1; k++) @(posedge clk_sys);
        check({31'h0, hw_trigger}, 32'h1, 32'h1);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h6, 32'h7);
        ahb(1'b0, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        check({31'h0, rd[7]}, 32'h1, 32'h1);
        check({31'h0, irq}, 32'h1, 32'h1);
        // Writing one to the flag clears it and drops the interrupt line
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'hc1, rd);
        ahb(1'b0, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        check({31'h0, rd[7]}, 32'h0, 32'h0);
        check({31'h0, irq}, 32'h0, 32'h0);
        repeat (20) @(posedge clk_sys);
        check({31'h0, hw_trigger}, 32'h0, 32'h0);
        // Compare changed only while disabled, so no flag handshake needed
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        ahb(1'b1, lptu_pkg::COMPARE_OFS, 32'h0, rd);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h1, rd);
        repeat (300) @(posedge clk_sys);
        check({31'h0, hw_trigger}, 32'h1, 32'h1);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        repeat (3) @(posedge clk_sys);
        check({31'h0, hw_trigger}, 32'h0, 32'h0);
        $display("test_compare done");
    endtask

    // Input high at enable gives no count; later edges count one each
    task automatic test_pulse_bypass();
        ahb(1'b1, lptu_pkg::PRESCALE_OFS, 32'h7, rd);
        i_far.set_level(1'b1);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h3, rd);
        repeat (10) @(posedge clk_sys);
        i_far.set_level(1'b0);
        i_far.pulses(4, 6, 6);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h4, 32'h4);
        // Active low: pin low at enable gives no count, each fall counts
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'hb, rd);
        i_far.pulses(2, 6, 6);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h2, 32'h2);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        $display("test_pulse_bypass done");
    endtask

    // Filter of two source edges: long pulses count, short glitches do not
    task automatic test_pulse_filter();
        ahb(1'b1, lptu_pkg::PRESCALE_OFS, 32'h8, rd);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h3, rd);
        repeat (40) @(posedge clk_sys);
        i_far.pulses(3, 50, 50);
        i_far.pulses(2, 3, 50);
        ahb(1'b0, lptu_pkg::COUNT_OFS, 32'h0, rd);
        check(rd, 32'h3, 32'h3);
        ahb(1'b1, lptu_pkg::CTRL_STATUS_OFS, 32'h0, rd);
        $display("test_pulse_filter done");
    endtask

    initial
    begin
        clk_sys = 1'b0;
        srst = 1'b1;
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        test_regs();
        time_count(2'h0, 1'b1, 4'h0, 415, 32'd47, 32'd51);
        time_count(2'h1, 1'b0, 4'h0, 635, 32'd23, 32'd26);
        time_count(2'h2, 1'b0, 4'h1, 1610, 32'd23, 32'd26);
        time_count(2'h3, 1'b1, 4'h0, 200, 32'd0, 32'd0);
        test_compare();
        test_pulse_bypass();
        test_pulse_filter();
        conclude();
    end
endmodule
